// File: core/edge_guard.sv
`timescale 1ns/100ps
// Samples the oscillator pin, filters spikes, flags missing edges
module edge_guard
  import osc_guard_pkg::*;
#(
  parameter int W = 12
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic osc_pin,
  input wire logic guard_on,
  output logic edge_ok,
  output logic edge_missing
);
  if (MISS_CYCLES >= (1 << W) || MISS_CYCLES <= GUARD_MIN_CYCLES)
  begin : g_bad_miss
    $error("edge_guard miss window out of range");
  end
  logic sync1_r; // First stage, read only by sync2_r
  logic sync2_r;
  logic last_r; // Previous synchronised level
  logic [W-1:0] gap_r; // Cycles since last accepted edge
  logic [W-1:0] low_r; // Cycles the input has been low
  logic ok_r;
  logic miss_r;
  logic [W-1:0] gap_nxt;
  logic [W-1:0] low_nxt;
  logic ok_nxt;
  logic miss_nxt;
  logic rise;
  logic accept;

  // A rise is believed only after enough low time and enough gap
  always_comb begin
    rise = sync2_r && !last_r;
    accept = rise && (!guard_on ||
      (low_r >= W'(SPIKE_MIN_CYCLES) &&
       gap_r >= W'(GUARD_MIN_CYCLES - 1)));
    ok_nxt = accept;
    gap_nxt = gap_r;
    if (accept) begin
      gap_nxt = '0;
    end else if (gap_r != W'(MISS_CYCLES)) begin
      gap_nxt = gap_r + W'(1);
    end
    low_nxt = low_r;
    if (sync2_r) begin
      low_nxt = '0;
    end else if (low_r != W'(MISS_CYCLES)) begin
      low_nxt = low_r + W'(1);
    end
    // Saturated gap means the edge did not come
    miss_nxt = (gap_nxt == W'(MISS_CYCLES));
  end

  // Registers only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      last_r <= 1'b0;
      gap_r <= '0;
      low_r <= '0;
      ok_r <= 1'b0;
      miss_r <= 1'b0;
    end else begin
      sync1_r <= osc_pin;
      sync2_r <= sync1_r;
      last_r <= sync2_r;
      gap_r <= gap_nxt;
      low_r <= low_nxt;
      ok_r <= ok_nxt;
      miss_r <= miss_nxt;
    end
  end

  assign edge_ok = ok_r;
  assign edge_missing = miss_r;
endmodule

// File: core/osc_guard_pkg.sv
// Behaviour
// - Divide internal clock by 12 and 13
// - Instructions last two, four or five cycles
// - Oscillator disable flag at 0D1h bit 2
// - Guard on and flag set: aux replaces main
// - Flag clear or reset restarts main oscillator
// - Restart waits start-up delay on aux clock
// - Aux starts one period after missing edge
// - Aux clock runs everything, only slower
// - Aux clocks power-on delay counter
// - Aux stops once main oscillator runs
// - Guard drops spikes and over-frequency cycles
// - Guard caps internal clock frequency
// - Guard chosen by fixed option
// - Programmable divider on internal clock
// - Option selects crystal or resistor source
// - Other control bits only feed converter
package osc_guard_pkg;
  // Clock rate of the supervising logic
  localparam int CLK_FREQ_HZ = 20_000_000;
  // Highest internal clock allowed while guarded
  localparam int GUARD_MAX_FREQ_HZ = 8_000_000;
  localparam int GUARD_MIN_CYCLES =
    (CLK_FREQ_HZ + GUARD_MAX_FREQ_HZ - 1) / GUARD_MAX_FREQ_HZ;
  // Auxiliary oscillator model frequency
  localparam int AUX_CLOCK_FREQ_HZ = 500_000;
  localparam int AUX_DIV_CYCLES = CLK_FREQ_HZ / AUX_CLOCK_FREQ_HZ;
  // Silence on the oscillator input that counts as a missing edge
  localparam int MISS_TIME_NS = 1000;
  localparam int MISS_CYCLES = MISS_TIME_NS / 50;
  // Least low time before a rising edge is believed
  localparam int SPIKE_MIN_CYCLES = 1;
  // Fixed dividers
  localparam int PERIPH_DIV = 12;
  localparam int CORE_DIV = 13;
  // Instruction lengths in machine cycles
  localparam logic [2:0] INSTR_LEN_2 = 3'h2;
  localparam logic [2:0] INSTR_LEN_4 = 3'h4;
  localparam logic [2:0] INSTR_LEN_5 = 3'h5;
  // Register indices and byte addresses
  localparam logic [7:0] CTRL_INDEX = 8'hD1;
  localparam logic [7:0] DIV_INDEX = 8'hF0;
  localparam logic [7:0] STAT_INDEX = 8'hF1;
  localparam logic [31:0] CTRL_ADDR = {22'h000000, CTRL_INDEX, 2'h0};
  localparam logic [31:0] DIV_ADDR = {22'h000000, DIV_INDEX, 2'h0};
  localparam logic [31:0] STAT_ADDR = {22'h000000, STAT_INDEX, 2'h0};
  // Control register layout and reset
  localparam int OSC_OFF_BIT = 2;
  localparam logic [7:0] CTRL_RESET = 8'h40;
  localparam logic [1:0] DIV_RESET = 2'h0;
  // Status bit positions
  localparam int STAT_AUX_BIT = 0;
  localparam int STAT_MISS_BIT = 1;
  localparam int STAT_POR_BIT = 2;
  localparam int STAT_MAIN_BIT = 3;
  // Clock source states
  typedef enum logic [3:0] {
    ST_MAIN = 4'h1,
    ST_MISSING = 4'h2,
    ST_AUX = 4'h4,
    ST_RESTART = 4'h8
  } src_state_type;
endpackage

// File: core/oscillator_safeguard_clock_ctrl.sv
`timescale 1ns/100ps
// Clock source selection, guard, dividers and register slave
module oscillator_safeguard_clock_ctrl
  import osc_guard_pkg::*;
#(
  parameter bit GUARD_ON = 1'b1, // Fixed safeguard option
  parameter bit RESISTOR_CLOCK = 1'b0, // Fixed source option
  parameter int STARTUP_EDGES = 64, // Main start-up delay in edges
  parameter int POR_TICKS = 2048 // Power-on delay in clock ticks
) (
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Oscillator side
  input wire logic oscillator_input_pin,
  output logic main_osc_enable,
  output logic low_freq_aux_clock,
  output logic resistor_clock_option,
  // Derived clock strobes
  output logic internal_tick,
  output logic periph_tick,
  output logic machine_tick,
  output logic por_done,
  // Instruction timing
  input wire logic instr_start,
  input wire logic [1:0] instr_len_sel,
  output logic instr_busy,
  output logic instr_done,
  // Converter control bits
  output logic [4:0] converter_ctrl_high_bits,
  output logic [1:0] converter_ctrl_low_bits
);
  if (STARTUP_EDGES < 1 || STARTUP_EDGES > 4095) begin : g_bad_start
    $error("STARTUP_EDGES must lie in 1..4095");
  end
  if (POR_TICKS < 1 || POR_TICKS > 4095) begin : g_bad_por
    $error("POR_TICKS must lie in 1..4095");
  end
  if (AUX_DIV_CYCLES < 2 || AUX_DIV_CYCLES > 255) begin : g_bad_aux
    $error("Auxiliary divider out of range");
  end

  // Programmable divide ratio from the two-bit selector
  function automatic logic [3:0] div_ratio(input logic [1:0] sel);
    logic [3:0] r;
    r = 4'h1;
    unique case (sel)
      2'h0: r = 4'h1;
      2'h1: r = 4'h2;
      2'h2: r = 4'h4;
      2'h3: r = 4'h8;
    endcase
    return r;
  endfunction

  // Instruction length from the selector; code 3 also means five
  function automatic logic [2:0] instr_len(input logic [1:0] sel);
    logic [2:0] n;
    n = INSTR_LEN_5;
    unique case (sel)
      2'h0: n = INSTR_LEN_2;
      2'h1: n = INSTR_LEN_4;
      2'h2: n = INSTR_LEN_5;
      2'h3: n = INSTR_LEN_5;
    endcase
    return n;
  endfunction

  // Bus address phase capture
  logic wr_pend_r; // Write waiting for its data phase
  logic [31:0] wr_addr_r;
  logic rd_valid_r;
  logic [31:0] rdata_r;
  logic wr_pend_nxt;
  logic [31:0] wr_addr_nxt;
  logic [31:0] rdata_nxt;
  logic addr_take;
  // Registers seen by software
  logic [7:0] ctrl_r; // Converter bits plus oscillator disable
  logic [1:0] div_r; // Internal clock divide selector
  logic [7:0] ctrl_nxt;
  logic [1:0] div_nxt;
  logic osc_off;
  // Source selection state
  src_state_type state_r;
  src_state_type state_nxt;
  logic [11:0] start_cnt_r; // Good main edges during restart
  logic [11:0] start_cnt_nxt;
  logic aux_clear;
  logic aux_run;
  logic aux_tick;
  logic src_tick;
  // Guard outputs
  logic edge_ok;
  logic edge_missing;
  // Power-on delay and instruction counters
  logic [11:0] por_cnt_r;
  logic [11:0] por_cnt_nxt;
  logic por_done_r;
  logic por_done_nxt;
  logic [2:0] instr_cnt_r; // Machine cycles still to run
  logic [2:0] instr_cnt_nxt;
  logic instr_done_r;
  logic instr_done_nxt;
  logic [7:0] status_word;

  // Take a transfer only when selected and the bus is ready
  assign addr_take = hsel && hready && htrans[1];

  // Decode reads now so data stand in the data phase
  always_comb begin
    wr_pend_nxt = addr_take && hwrite;
    wr_addr_nxt = wr_addr_r;
    rdata_nxt = 32'h00000000;
    if (addr_take) begin
      wr_addr_nxt = haddr;
    end
    if (addr_take && !hwrite) begin
      // Unmapped offsets read as zero
      unique case (haddr)
        CTRL_ADDR: rdata_nxt = {24'h000000, ctrl_r};
        DIV_ADDR: rdata_nxt = {30'h00000000, div_r};
        STAT_ADDR: rdata_nxt = {24'h000000, status_word};
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  // Bus registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 32'h00000000;
      rd_valid_r <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      rd_valid_r <= addr_take && !hwrite;
      rdata_r <= rdata_nxt;
    end
  end

  // Zero wait states, never an error
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_r;

  // Register writes land in the data phase
  always_comb begin
    ctrl_nxt = ctrl_r;
    div_nxt = div_r;
    if (wr_pend_r && wr_addr_r == CTRL_ADDR) begin
      ctrl_nxt = hwdata[7:0];
    end
    if (wr_pend_r && wr_addr_r == DIV_ADDR) begin
      div_nxt = hwdata[1:0];
    end
  end

  // Reset clears the disable flag, so main runs again
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= CTRL_RESET;
      div_r <= DIV_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
      div_r <= div_nxt;
    end
  end

  // Converter bits pass straight out, never into clocking
  assign converter_ctrl_high_bits = ctrl_r[7:3];
  assign converter_ctrl_low_bits = ctrl_r[1:0];
  // Flag only acts with the guard option built in
  assign osc_off = GUARD_ON && ctrl_r[OSC_OFF_BIT];
  assign main_osc_enable = !osc_off;
  assign resistor_clock_option = RESISTOR_CLOCK;

  // Main pin through sync, spike filter and miss detect
  edge_guard #(
    .W(12)
  ) u_edge_guard (
    .hclk(hclk),
    .hresetn(hresetn),
    .osc_pin(oscillator_input_pin),
    .guard_on(GUARD_ON),
    .edge_ok(edge_ok),
    .edge_missing(edge_missing)
  );

  // Source selection; aux exists only with the guard option
  always_comb begin
    state_nxt = state_r;
    start_cnt_nxt = start_cnt_r;
    aux_clear = 1'b0;
    unique case (state_r)
      ST_MAIN: begin
        // Any cause of silence hands over to aux
        if (GUARD_ON && edge_missing) begin
          state_nxt = ST_MISSING;
          aux_clear = 1'b1;
        end
      end
      ST_MISSING: begin
        // No clock for one full aux period
        if (aux_tick) begin
          state_nxt = ST_AUX;
        end
      end
      ST_AUX: begin
        if (!osc_off) begin
          state_nxt = ST_RESTART;
          start_cnt_nxt = 12'h000;
        end
      end
      ST_RESTART: begin
        // Aux keeps clocking while main proves itself
        if (osc_off) begin
          state_nxt = ST_AUX;
        end else if (edge_missing) begin
          start_cnt_nxt = 12'h000;
        end else if (edge_ok) begin
          if (start_cnt_r == 12'(STARTUP_EDGES - 1)) begin
            // Switch only on a main edge: full new period ahead
            state_nxt = ST_MAIN;
          end else begin
            start_cnt_nxt = start_cnt_r + 12'h001;
          end
        end
      end
      default: begin
        state_nxt = ST_MAIN;
      end
    endcase
  end

  // Power-up starts on aux when guarded, since aux is faster up
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= GUARD_ON ? ST_RESTART : ST_MAIN;
      start_cnt_r <= 12'h000;
    end else begin
      state_r <= state_nxt;
      start_cnt_r <= start_cnt_nxt;
    end
  end

  // Aux runs in every state but main
  assign aux_run = (state_r != ST_MAIN);
  assign low_freq_aux_clock = aux_run;

  // Aux oscillator model, restarted so its first period is whole
  tick_divider #(
    .W(8)
  ) u_aux_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(aux_clear || !aux_run),
    .step(1'b1),
    .modulus(8'(AUX_DIV_CYCLES)),
    .tick(aux_tick)
  );

  // One source at a time feeds the internal clock
  always_comb begin
    src_tick = 1'b0;
    unique case (state_r)
      ST_MAIN: src_tick = edge_ok;
      ST_MISSING: src_tick = 1'b0;
      ST_AUX: src_tick = aux_tick;
      ST_RESTART: src_tick = aux_tick;
      default: src_tick = 1'b0;
    endcase
  end

  // Software divider trades speed against power
  tick_divider #(
    .W(4)
  ) u_prog_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(1'b0),
    .step(src_tick),
    .modulus(div_ratio(div_r)),
    .tick(internal_tick)
  );

  // Timer, converter and watchdog strobe
  tick_divider #(
    .W(4)
  ) u_periph_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(1'b0),
    .step(internal_tick),
    .modulus(4'(PERIPH_DIV)),
    .tick(periph_tick)
  );

  // Core machine cycle strobe
  tick_divider #(
    .W(4)
  ) u_core_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(1'b0),
    .step(internal_tick),
    .modulus(4'(CORE_DIV)),
    .tick(machine_tick)
  );

  // Power-on delay counts whatever clock is live, aux first
  always_comb begin
    por_cnt_nxt = por_cnt_r;
    por_done_nxt = por_done_r;
    if (!por_done_r && internal_tick) begin
      if (por_cnt_r == 12'(POR_TICKS - 1)) begin
        por_done_nxt = 1'b1;
      end else begin
        por_cnt_nxt = por_cnt_r + 12'h001;
      end
    end
  end

  // Power-on delay registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      por_cnt_r <= 12'h000;
      por_done_r <= 1'b0;
    end else begin
      por_cnt_r <= por_cnt_nxt;
      por_done_r <= por_done_nxt;
    end
  end

  assign por_done = por_done_r;

  // Instruction length in machine cycles; start ignored while busy
  always_comb begin
    instr_cnt_nxt = instr_cnt_r;
    instr_done_nxt = 1'b0;
    if (instr_cnt_r == 3'h0) begin
      if (instr_start) begin
        instr_cnt_nxt = instr_len(instr_len_sel);
      end
    end else if (machine_tick) begin
      instr_cnt_nxt = instr_cnt_r - 3'h1;
      instr_done_nxt = (instr_cnt_r == 3'h1);
    end
  end

  // Instruction timing registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      instr_cnt_r <= 3'h0;
      instr_done_r <= 1'b0;
    end else begin
      instr_cnt_r <= instr_cnt_nxt;
      instr_done_r <= instr_done_nxt;
    end
  end

  assign instr_busy = (instr_cnt_r != 3'h0);
  assign instr_done = instr_done_r;

  // Status word shows live clocking state
  always_comb begin
    status_word = 8'h00;
    status_word[STAT_AUX_BIT] = aux_run;
    status_word[STAT_MISS_BIT] = edge_missing;
    status_word[STAT_POR_BIT] = por_done_r;
    status_word[STAT_MAIN_BIT] = (state_r == ST_MAIN);
  end
endmodule

// File: core/tick_divider.sv
`timescale 1ns/100ps
// Modulo counter on a step strobe, one-cycle tick at wrap
module tick_divider
  import osc_guard_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clear,
  input wire logic step,
  input wire logic [W-1:0] modulus,
  output logic tick
);
  if (W < 2) begin : g_bad_width
    $error("tick_divider needs at least two bits");
  end
  logic [W-1:0] count_r; // Steps seen in this period
  logic [W-1:0] count_nxt;
  logic tick_r; // Registered so consumers see a clean pulse
  logic tick_nxt;

  // Next count; clear restarts a full period
  always_comb begin
    count_nxt = count_r;
    tick_nxt = 1'b0;
    if (clear) begin
      count_nxt = '0;
    end else if (step) begin
      if (count_r >= modulus - W'(1)) begin
        count_nxt = '0;
        tick_nxt = 1'b1;
      end else begin
        count_nxt = count_r + W'(1);
      end
    end
  end

  // Registers only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_r <= '0;
      tick_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;
endmodule

// File: verif/osc_guard_monitor.sv
`timescale 1ns/100ps
// Port checks on the clock controller
module osc_guard_monitor
  import osc_guard_pkg::*;
#(
  parameter bit RESISTOR_CLOCK = 1'b0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic main_osc_enable,
  input wire logic low_freq_aux_clock,
  input wire logic resistor_clock_option,
  input wire logic internal_tick,
  input wire logic periph_tick,
  input wire logic machine_tick,
  input wire logic por_done,
  input wire logic instr_start,
  input wire logic [1:0] instr_len_sel,
  input wire logic instr_busy,
  input wire logic instr_done,
  input wire logic [4:0] converter_ctrl_high_bits
);
  logic take; // Address phase accepted
  logic wr_r, wr_nxt; // Control write data phase
  logic rd_r, rd_nxt; // Read data phase
  logic [3:0] pcnt_r, pcnt_nxt; // Ticks since periph tick
  logic [3:0] mcnt_r, mcnt_nxt; // Ticks since machine tick
  logic [1:0] seen_r, seen_nxt; // Whole group under way
  logic aux_r, aux_nxt; // Last source seen
  logic [2:0] icnt_r, icnt_nxt; // Machine ticks so far
  logic [2:0] ilen_r, ilen_nxt; // Expected length
  assign take = hsel && hready && htrans[1];
  // Helper counters
  always_comb begin
    wr_nxt = take && hwrite && haddr == CTRL_ADDR;
    rd_nxt = take && !hwrite;
    pcnt_nxt = periph_tick ? 4'h0 : pcnt_r + 4'(internal_tick);
    mcnt_nxt = machine_tick ? 4'h0 : mcnt_r + 4'(internal_tick);
    seen_nxt = seen_r | {machine_tick, periph_tick};
    aux_nxt = low_freq_aux_clock;
    // Bus transfers and source switches void the group counts
    if (take || aux_r != low_freq_aux_clock) begin
      seen_nxt = 2'h0;
    end
    icnt_nxt = icnt_r + 3'(instr_busy && machine_tick);
    ilen_nxt = ilen_r;
    if (instr_start && !instr_busy) begin
      icnt_nxt = 3'h0;
      ilen_nxt = instr_len_sel == 2'h0 ? INSTR_LEN_2 :
        (instr_len_sel == 2'h1 ? INSTR_LEN_4 : INSTR_LEN_5);
    end
  end
  // Register the helpers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wr_r, rd_r, pcnt_r, mcnt_r, seen_r, aux_r, icnt_r, ilen_r} <= '0;
    end else begin
      {wr_r, rd_r, pcnt_r, mcnt_r} <= {wr_nxt, rd_nxt, pcnt_nxt, mcnt_nxt};
      {seen_r, aux_r, icnt_r, ilen_r} <=
        {seen_nxt, aux_nxt, icnt_nxt, ilen_nxt};
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  bus_answer_a: assert property (hreadyout && !hresp)
    else $error("Bad bus answer");
  flag_write_a: assert property (wr_r |=>
    main_osc_enable == !$past(hwdata[OSC_OFF_BIT]) &&
    converter_ctrl_high_bits == $past(hwdata[7:3]))
    else $error("Control write lost");
  read_idle_a: assert property (!rd_r |-> hrdata == 32'h0)
    else $error("Stray read data");
  source_opt_a: assert property (
    resistor_clock_option == RESISTOR_CLOCK)
    else $error("Source option wrong");
  periph_div_a: assert property (periph_tick && seen_r[0] |->
    pcnt_r + 4'(internal_tick) == 4'hC)
    else $error("Periph divide wrong");
  machine_div_a: assert property (machine_tick && seen_r[1] |->
    mcnt_r + 4'(internal_tick) == 4'hD)
    else $error("Machine divide wrong");
  instr_len_a: assert property (instr_done |-> icnt_r == ilen_r)
    else $error("Instruction length wrong");
  aux_start_a: assert property ($fell(main_osc_enable) |->
    ##[1:60] low_freq_aux_clock)
    else $error("Aux did not start");
  freq_cap_a: assert property (internal_tick |=> !internal_tick [*2])
    else $error("Internal clock above cap");
  por_hold_a: assert property (por_done |=> por_done)
    else $error("Power-on done dropped");
endmodule

// File: verif/osc_source_model.sv
`timescale 1ns/100ps
// External clock source on the oscillator pin
module osc_source_model (
  input wire logic enable,
  input wire logic slow,
  output logic pin
);
  // Off-grid start keeps pin edges away from hclk edges
  initial begin
    pin = 1'b0;
    #12;
    forever begin
      // Half period 100 ns, or 250 ns when slow
      if (slow) begin
        #150;
      end
      #100;
      // Disabled: stops low
      pin = enable ? ~pin : 1'b0;
    end
  end
endmodule

// File: verif/testbench.sv
`timescale 1ns/100ps
// Bench for the clock controller
module testbench;
  import osc_guard_pkg::*;
  localparam int LIMIT = 20000; // Run ceiling in cycles
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2; // Whole words only
  logic [31:0] hwdata = 32'h0;
  logic instr_start = 1'b0;
  logic [1:0] instr_len_sel = 2'h0;
  logic slow = 1'b0; // Slow source
  logic [31:0] hrdata;
  logic hreadyout, hresp, oscillator_input_pin, main_osc_enable;
  logic low_freq_aux_clock, resistor_clock_option, internal_tick;
  logic periph_tick, machine_tick, por_done, instr_busy, instr_done;
  logic [4:0] converter_ctrl_high_bits;
  logic [1:0] converter_ctrl_low_bits;
  logic [2:0] mticks = 3'h0; // Machine ticks so far
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  always #25 hclk = ~hclk;
  oscillator_safeguard_clock_ctrl #(.GUARD_ON(1'b1),
    .RESISTOR_CLOCK(1'b0), .STARTUP_EDGES(2), .POR_TICKS(4))
  oscillator_safeguard_clock_ctrl_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .oscillator_input_pin(oscillator_input_pin),
    .main_osc_enable(main_osc_enable),
    .low_freq_aux_clock(low_freq_aux_clock),
    .resistor_clock_option(resistor_clock_option),
    .internal_tick(internal_tick), .periph_tick(periph_tick),
    .machine_tick(machine_tick), .por_done(por_done),
    .instr_start(instr_start), .instr_len_sel(instr_len_sel),
    .instr_busy(instr_busy), .instr_done(instr_done),
    .converter_ctrl_high_bits(converter_ctrl_high_bits),
    .converter_ctrl_low_bits(converter_ctrl_low_bits));
  osc_source_model osc_source_model_inst (.enable(main_osc_enable),
    .slow(slow), .pin(oscillator_input_pin));
  // Hang guard and machine tick count
  always @(posedge hclk) begin
    cycles++;
    mticks <= (instr_start && !instr_busy) ? 3'h0 :
      mticks + 3'(instr_busy && machine_tick);
    if (cycles == LIMIT) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Single write; each phase held until hready is sampled high
  task automatic ahb_write(input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= 1'b1;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    @(negedge hclk);
  endtask
  // Single read; data taken at the edge ending the data phase
  task automatic ahb_read(input logic [31:0] a, output logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= 1'b0;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  // Whole gap between ticks; the first gap may be partial
  task automatic tick_gap(output int g);
    repeat (2) do @(negedge hclk); while (internal_tick !== 1'b1);
    g = 0;
    do begin
      @(negedge hclk);
      g++;
    end while (internal_tick !== 1'b1);
  endtask
  // Internal ticks per group
  task automatic div_count(input bit mach, output int n);
    do @(negedge hclk); while ((mach ? machine_tick : periph_tick) !== 1'b1);
    n = 0;
    do begin
      @(negedge hclk);
      n += (internal_tick === 1'b1);
    end while ((mach ? machine_tick : periph_tick) !== 1'b1);
  endtask
  task automatic t_reset();
    logic [31:0] d;
    check("osc enable", main_osc_enable, 32'h1);
    check("conv high", converter_ctrl_high_bits, 32'h08);
    check("conv low", converter_ctrl_low_bits, 32'h0);
    ahb_read(CTRL_ADDR, d);
    check("ctrl reset", d, 32'h40);
    ahb_read(DIV_ADDR, d);
    check("div reset", d, 32'h0);
    ahb_write(32'h100, 32'hFF);
    ahb_read(32'h100, d);
    check("unmapped", d, 32'h0);
    ahb_read(CTRL_ADDR, d);
    check("ctrl kept", d, 32'h40);
    do @(negedge hclk); while (por_done !== 1'b1);
    ahb_read(STAT_ADDR, d);
    check("status main", d, 32'h0C);
    check("aux off", low_freq_aux_clock, 32'h0);
    $display("Test run done");
  endtask
  task automatic t_div();
    int g;
    logic [2:0] len [4];
    for (int k = 3; k >= 0; k--) begin
      ahb_write(DIV_ADDR, k);
      tick_gap(g);
      check("div gap", g, 4 << k);
    end
    div_count(1'b0, g);
    check("periph group", g, PERIPH_DIV);
    div_count(1'b1, g);
    check("machine group", g, CORE_DIV);
    slow <= 1'b1;
    tick_gap(g);
    check("slow gap", g, 10);
    slow <= 1'b0;
    len = '{INSTR_LEN_2, INSTR_LEN_4, INSTR_LEN_5, INSTR_LEN_5};
    for (int k = 0; k < 4; k++) begin
      @(posedge hclk);
      instr_len_sel <= 2'(k);
      instr_start <= 1'b1;
      @(posedge hclk);
      instr_start <= 1'b0;
      repeat (3) @(posedge hclk);
      instr_start <= 1'b1; // Ignored while busy
      @(posedge hclk);
      instr_start <= 1'b0;
      do @(negedge hclk); while (instr_done !== 1'b1);
      check("instr len", mticks, len[k]);
    end
    $display("Test instructions done");
  endtask
  task automatic t_main_osc_disable();
    logic [31:0] d;
    int g;
    ahb_read(CTRL_ADDR, d);
    ahb_write(CTRL_ADDR, d | 32'h4);
    check("osc off", main_osc_enable, 32'h0);
    check("conv kept", converter_ctrl_high_bits, d[7:3]);
    for (g = 0; g < 80 && low_freq_aux_clock !== 1'b1; g++) @(negedge hclk);
    check("aux on", low_freq_aux_clock, 32'h1);
    tick_gap(g);
    check("aux gap", g, AUX_DIV_CYCLES);
    div_count(1'b0, g);
    check("aux periph", g, PERIPH_DIV);
    ahb_read(STAT_ADDR, d);
    check("status aux", d & 32'h9, 32'h1);
    ahb_read(CTRL_ADDR, d);
    ahb_write(CTRL_ADDR, d & ~32'h4);
    check("osc on", main_osc_enable, 32'h1);
    check("aux bridges", low_freq_aux_clock, 32'h1);
    for (g = 0; g < 200 && low_freq_aux_clock !== 1'b0; g++) @(negedge hclk);
    check("aux stops", low_freq_aux_clock, 32'h0);
    tick_gap(g);
    check("main gap", g, 4);
    ahb_write(CTRL_ADDR, 32'h44);
    check("off before reset", main_osc_enable, 32'h0);
    @(posedge hclk);
    hresetn <= 1'b0;
    @(negedge hclk);
    check("reset restarts", main_osc_enable, 32'h1);
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    do @(negedge hclk); while (por_done !== 1'b1);
    check("por again", por_done, 32'h1);
    $display("Test reset restart done");
  endtask
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_div();
    t_main_osc_disable();
    wrap_up();
  end
endmodule
bind oscillator_safeguard_clock_ctrl osc_guard_monitor #(
  .RESISTOR_CLOCK(RESISTOR_CLOCK)) osc_guard_monitor_inst (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .main_osc_enable(main_osc_enable),
  .low_freq_aux_clock(low_freq_aux_clock),
  .resistor_clock_option(resistor_clock_option),
  .internal_tick(internal_tick), .periph_tick(periph_tick),
  .machine_tick(machine_tick), .por_done(por_done),
  .instr_start(instr_start), .instr_len_sel(instr_len_sel),
  .instr_busy(instr_busy), .instr_done(instr_done),
  .converter_ctrl_high_bits(converter_ctrl_high_bits));
